// [hdl/rcp_regs.svh]
// Constants for the remote command parser
`ifndef RCP_REGS_SVH
`define RCP_REGS_SVH

// ----------------------------------------
// Serial link timing
// ----------------------------------------
`define RCP_CLK_HZ 100000000
`define RCP_BAUD 9600
`define RCP_CNT_W 16

// ----------------------------------------
// Pin idle levels: serial mark, bus lines released
// ----------------------------------------
`define RCP_PIN_IDLE 13'h1000

// ----------------------------------------
// Character codes (7-bit)
// ----------------------------------------
`define RCP_CH_CR 7'h0D
`define RCP_CH_LF 7'h0A
`define RCP_CH_TAB 7'h09
`define RCP_CH_SP 7'h20
`define RCP_CH_COMMA 7'h2C
`define RCP_CH_DOT 7'h2E
`define RCP_CH_SLASH 7'h2F
`define RCP_CH_SEMI 7'h3B
`define RCP_CH_STAR 7'h2A
`define RCP_CH_QUERY 7'h3F
`define RCP_CH_ONE 7'h31
`define RCP_CH_XON 7'h11
`define RCP_CH_XOFF 7'h13
`define RCP_CH_LA 7'h61
`define RCP_CH_LZ 7'h7A
`define RCP_CH_UA 7'h41
`define RCP_CH_UZ 7'h5A
`define RCP_CH_D0 7'h30
`define RCP_CH_D9 7'h39
`define RCP_CASE 7'h20

// ----------------------------------------
// Token buffers
// ----------------------------------------
`define RCP_TOK_MAX 4'h8
`define RCP_TOK_OVF 4'h9
`define RCP_PEND_MAX 4'hF

// ----------------------------------------
// Headers handled here (right-aligned)
// ----------------------------------------
`define RCP_H_WAI 64'h2A574149
`define RCP_H_OPC 64'h2A4F5043
`define RCP_H_OPCQ 64'h2A4F50433F
`define RCP_H_IDNQ 64'h2A49444E3F
`define RCP_H_LOCAL 64'h4C4F43414C
`define RCP_H_REMOTE 64'h52454D4F5445
`define RCP_H_LOCKOUT 64'h4C4F434B4F5554

// ----------------------------------------
// Bus interface messages (ATN true)
// ----------------------------------------
`define RCP_M_GTL 7'h01
`define RCP_M_SDC 7'h04
`define RCP_M_GET 7'h08
`define RCP_M_LLO 7'h11
`define RCP_M_DCL 7'h14
`define RCP_M_UNL 7'h3F
`define RCP_M_LAG 2'h1

// ----------------------------------------
// Identification reply (value arbitrary)
// ----------------------------------------
`define RCP_ID_LEN 5'hC
`define RCP_ID_STR 96'h43414C2C50432C302C312E30

// ----------------------------------------
// Accepted unit suffixes, folded
// ----------------------------------------
`define RCP_N_UNITS 27
`define RCP_UNITS '{ \
  64'h5556, 64'h4D56, 64'h56, 64'h4B56, 64'h5541, \
  64'h4D41, 64'h41, 64'h4F484D, 64'h4B4F484D, \
  64'h4D4F484D, 64'h43454C, 64'h464152, 64'h505349, \
  64'h4D4D4847, 64'h494E4847, 64'h494E48324F3443, \
  64'h494E48324F323043, 64'h494E48324F363046, \
  64'h434D48324F3443, 64'h434D48324F323043, \
  64'h4D4D48324F3443, 64'h4D4D48324F323043, \
  64'h424152, 64'h4D424152, 64'h4B5041, 64'h4D5041, \
  64'h4B472F434D32}

`endif

// [hdl/rcp_pkg.sv]
// Types shared by the remote command parser
package rcp_pkg;

  // ----------------------------------------
  // Dispatched command
  // ----------------------------------------
  typedef struct packed {
    logic [63:0] header;  // Right-aligned name
    logic [63:0] unit;    // Right-aligned suffix
    logic has_unit;       // Suffix present
    logic common;         // Starts with asterisk
    logic query;          // Ends with question mark
    logic from_serial;    // Arrived on serial link
  } rcp_cmd_t;

  // ----------------------------------------
  // Response byte
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;     // Character
    logic last;           // Terminator byte
    logic to_serial;      // Route to serial link
  } rcp_resp_t;

  // Local/remote operating states
  typedef enum logic [1:0] {
    RL_LOCS, RL_LWLS, RL_REMS, RL_RWLS
  } rcp_rl_t;

endpackage : rcp_pkg

// [hdl/rcp_unit_match.sv]
// Unit suffix lookup against the accepted set
`timescale 1ns/1ps
`default_nettype none
`include "rcp_regs.svh"

module rcp_unit_match (
  input wire logic [63:0] unit,
  input wire logic [3:0] unit_len,
  output logic ok
);

  // ----------------------------------------
  // Table compare
  // ----------------------------------------
  localparam logic [63:0] TABLE [`RCP_N_UNITS] = `RCP_UNITS;

  logic [`RCP_N_UNITS-1:0] hit; // One bit per entry

  // One comparator per accepted suffix
  genvar i;
  generate
    for (i = 0; i < `RCP_N_UNITS; i++) begin : g_unit
      assign hit[i] = (unit == TABLE[i]);
    end
  endgenerate

  // Overlong suffix can never match
  assign ok = (|hit) && (unit_len <= `RCP_TOK_MAX);

endmodule : rcp_unit_match
`default_nettype wire

// [hdl/rcp_parser.sv]
// Remote command parser: serial and parallel bus front end
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "rcp_regs.svh"

module rcp_parser #(
  parameter int BIT_CYCLES = `RCP_CLK_HZ / `RCP_BAUD
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ser_rx,
  input wire logic [7:0] bus_dio,
  input wire logic bus_dav,
  input wire logic bus_atn,
  input wire logic bus_eoi,
  input wire logic bus_ren,
  input wire logic [4:0] bus_addr,
  input wire logic panel_local,
  output logic bus_hold,
  output logic listen,
  output rcp_pkg::rcp_cmd_t cmd,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic ovl_start,
  input wire logic ovl_done,
  output logic opc_event,
  output logic cmd_error,
  output rcp_pkg::rcp_resp_t resp,
  output logic resp_valid,
  input wire logic resp_ready,
  output logic dev_clear,
  output logic dev_trigger,
  output logic remote,
  output logic lockout
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [12:0] pin_meta; // First stage only
  logic [12:0] pin_sync; // Safe to read
  logic dav_d;           // Edge detect
  logic ren_d;           // Edge detect

  // Two flops on every pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Idle levels, so the edge detectors see no false DAV edge after reset
      pin_meta <= `RCP_PIN_IDLE;
      pin_sync <= `RCP_PIN_IDLE;
      dav_d <= 1'b0;
      ren_d <= 1'b0;
    end else begin
      pin_meta <= {ser_rx, bus_dav, bus_atn, bus_eoi, bus_ren, bus_dio};
      pin_sync <= pin_meta;
      dav_d <= pin_sync[11];
      ren_d <= pin_sync[8];
    end
  end

  logic rx_s;
  logic dav_rise;
  logic ren_s;
  logic [6:0] dio7;
  assign rx_s = pin_sync[12];
  assign dav_rise = pin_sync[11] && !dav_d;
  assign ren_s = pin_sync[8];
  assign dio7 = pin_sync[6:0]; // Top data bit ignored

  // ----------------------------------------
  // Serial receiver, 8N1
  // ----------------------------------------
  typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} rcp_ust_t;
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);
  rcp_ust_t ust, next_ust;
  logic [15:0] ucnt, next_ucnt;
  logic [2:0] ubit, next_ubit;
  logic [7:0] ush, next_ush;
  logic ser_v, next_ser_v;   // Byte ready pulse
  logic ser_fe, next_ser_fe; // Framing error pulse

  // Bit timing from the local clock
  always_comb begin
    next_ust = ust;
    next_ucnt = ucnt + 16'h1;
    next_ubit = ubit;
    next_ush = ush;
    next_ser_v = 1'b0;
    next_ser_fe = 1'b0;
    case (ust)
      U_IDLE: begin
        next_ucnt = 16'h0;
        if (!rx_s) next_ust = U_START;
      end
      U_START: begin // Recheck at mid bit
        if (ucnt == HALF) begin
          next_ucnt = 16'h0;
          next_ubit = 3'h0;
          next_ust = rx_s ? U_IDLE : U_DATA;
        end
      end
      U_DATA: begin
        if (ucnt == FULL) begin
          next_ucnt = 16'h0;
          next_ush = {rx_s, ush[7:1]};
          next_ubit = ubit + 3'h1;
          if (ubit == 3'h7) next_ust = U_STOP;
        end
      end
      U_STOP: begin
        if (ucnt == FULL) begin
          next_ust = U_IDLE;
          next_ser_v = rx_s;
          next_ser_fe = !rx_s;
        end
      end
      default: next_ust = U_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ust <= U_IDLE;
      ucnt <= 16'h0;
      ubit <= 3'h0;
      ush <= 8'h00;
      ser_v <= 1'b0;
      ser_fe <= 1'b0;
    end else begin
      ust <= next_ust;
      ucnt <= next_ucnt;
      ubit <= next_ubit;
      ush <= next_ush;
      ser_v <= next_ser_v;
      ser_fe <= next_ser_fe;
    end
  end

  // ----------------------------------------
  // Bus message decode and input slot
  // ----------------------------------------
  typedef enum logic [2:0] {
    P_COLLECT, P_EVAL, P_DISP, P_WAIT, P_RESP
  } rcp_pst_t;
  rcp_pst_t pst, next_pst;

  logic in_v, next_in_v;       // Slot holds a byte
  logic [6:0] in_ch, next_in_ch;
  logic in_end, next_in_end;   // Byte ends the line
  logic in_ser, next_in_ser;   // Byte came from serial
  logic next_listen;
  logic next_dev_clear;
  logic next_dev_trigger;
  logic overrun;               // Serial byte lost
  logic atn_msg;               // Message byte strobed
  logic gtl_p, llo_p, mla_p;   // Message pulses
  logic take;                  // Parser consumes slot

  assign take = in_v && (pst == P_COLLECT);
  assign atn_msg = dav_rise && pin_sync[10];
  assign mla_p = atn_msg && (dio7 == {`RCP_M_LAG, bus_addr});
  assign gtl_p = atn_msg && listen && (dio7 == `RCP_M_GTL);
  assign llo_p = atn_msg && (dio7 == `RCP_M_LLO);
  assign overrun = ser_v && in_v && !take;

  // Slot filling; the bus is held off, serial cannot be
  always_comb begin
    next_in_v = in_v && !take;
    next_in_ch = in_ch;
    next_in_end = in_end;
    next_in_ser = in_ser;
    next_listen = listen;
    next_dev_clear = 1'b0;
    next_dev_trigger = 1'b0;
    if (atn_msg) begin
      if (mla_p) next_listen = 1'b1;
      if (dio7 == `RCP_M_UNL) next_listen = 1'b0;
      next_dev_clear = (dio7 == `RCP_M_DCL) || (listen && dio7 == `RCP_M_SDC);
      next_dev_trigger = listen && (dio7 == `RCP_M_GET);
    end
    if (dav_rise && !pin_sync[10] && listen && !next_in_v) begin
      next_in_v = 1'b1;
      next_in_ch = dio7;
      next_in_end = pin_sync[9] || (dio7 == `RCP_CH_CR);
      next_in_ser = 1'b0;
    end else if (ser_v && !next_in_v && ush[6:0] != `RCP_CH_XON
                 && ush[6:0] != `RCP_CH_XOFF) begin
      next_in_v = 1'b1;
      next_in_ch = ush[6:0];
      next_in_end = (ush[6:0] == `RCP_CH_CR) || (ush[6:0] == `RCP_CH_LF);
      next_in_ser = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_v <= 1'b0;
      in_ch <= 7'h00;
      in_end <= 1'b0;
      in_ser <= 1'b0;
      listen <= 1'b0;
      dev_clear <= 1'b0;
      dev_trigger <= 1'b0;
    end else begin
      in_v <= next_in_v;
      in_ch <= next_in_ch;
      in_end <= next_in_end;
      in_ser <= next_in_ser;
      listen <= next_listen;
      dev_clear <= next_dev_clear;
      dev_trigger <= next_dev_trigger;
    end
  end

  // Bus listener must not strobe while the slot is full
  assign bus_hold = in_v;

  // ----------------------------------------
  // Character classes
  // ----------------------------------------
  logic [6:0] ch;  // Folded character
  logic is_alpha;
  logic is_digit;
  logic is_blank;
  assign ch = (in_ch >= `RCP_CH_LA && in_ch <= `RCP_CH_LZ) ?
              (in_ch - `RCP_CASE) : in_ch;
  assign is_alpha = (ch >= `RCP_CH_UA) && (ch <= `RCP_CH_UZ);
  assign is_digit = (ch >= `RCP_CH_D0) && (ch <= `RCP_CH_D9);
  assign is_blank = (ch == `RCP_CH_SP) || (ch == `RCP_CH_TAB);

  // ----------------------------------------
  // Parser and dispatcher
  // ----------------------------------------
  logic [63:0] hdr, next_hdr;
  logic [3:0] hlen, next_hlen;
  logic [6:0] first, next_first;
  logic [63:0] unit, next_unit;
  logic [3:0] ulen, next_ulen;
  logic in_prm, next_in_prm;   // Past the header
  logic in_unit, next_in_unit; // Inside a suffix
  logic num, next_num;         // Number just seen
  logic last_q, next_last_q;   // Last printable was '?'
  logic part_ser, next_part_ser;
  logic wai, next_wai;         // Waiting kind
  logic [3:0] pend, next_pend; // Overlapped in flight
  logic opc_arm, next_opc_arm;
  logic [4:0] ridx, next_ridx;
  logic rsel, next_rsel;       // 1: completion reply
  rcp_pkg::rcp_cmd_t next_cmd;
  rcp_pkg::rcp_resp_t next_resp;
  logic next_opc_event;
  logic next_cmd_error;
  logic ser_loc, ser_rem, ser_llo; // Serial state cmds
  logic unit_ok;
  localparam logic [95:0] ID_STR = `RCP_ID_STR; // Arbitrary

  rcp_unit_match u_unit (
    .unit(unit),
    .unit_len(ulen),
    .ok(unit_ok)
  );

  // Reply character at an index
  function automatic logic [7:0] reply_char(
    input logic sel, input logic [4:0] idx);
    if (sel) return (idx == 5'h0) ? {1'b0, `RCP_CH_ONE} : {1'b0, `RCP_CH_CR};
    if (idx < `RCP_ID_LEN) return ID_STR[8 * (`RCP_ID_LEN - 5'h1 - idx) +: 8];
    return {1'b0, `RCP_CH_CR};
  endfunction : reply_char

  // Collect a part, judge it, then hand it on
  always_comb begin
    next_pst = pst;
    next_hdr = hdr;
    next_hlen = hlen;
    next_first = first;
    next_unit = unit;
    next_ulen = ulen;
    next_in_prm = in_prm;
    next_in_unit = in_unit;
    next_num = num;
    next_last_q = last_q;
    next_part_ser = part_ser;
    next_wai = wai;
    next_opc_arm = opc_arm;
    next_ridx = ridx;
    next_rsel = rsel;
    next_cmd = cmd;
    next_resp = resp;
    next_opc_event = 1'b0;
    next_cmd_error = overrun || ser_fe;
    ser_loc = 1'b0;
    ser_rem = 1'b0;
    ser_llo = 1'b0;
    // Overlapped work runs beside parsing
    next_pend = pend + {3'h0, ovl_start && pend != `RCP_PEND_MAX}
                - {3'h0, ovl_done && pend != 4'h0};
    if (opc_arm && pend == 4'h0) begin
      next_opc_arm = 1'b0;
      next_opc_event = 1'b1;
    end
    case (pst)
      P_COLLECT: begin
        if (take) begin
          next_part_ser = in_ser;
          if (in_end || ch == `RCP_CH_SEMI) begin
            next_pst = P_EVAL;
          end else if (!in_prm) begin
            if (is_blank) begin
              next_in_prm = (hlen != 4'h0);
            end else if (hlen != `RCP_TOK_OVF) begin
              next_hdr = {hdr[55:0], 1'b0, ch};
              next_hlen = hlen + 4'h1;
              if (hlen == 4'h0) next_first = ch;
            end
          end else if (in_unit && (is_alpha || is_digit || ch == `RCP_CH_SLASH)) begin
            next_unit = {unit[55:0], 1'b0, ch};
            if (ulen != `RCP_TOK_OVF) next_ulen = ulen + 4'h1;
          end else if (is_alpha && num) begin // Suffix after a number
            next_unit = {57'h0, ch};
            next_ulen = 4'h1;
            next_in_unit = 1'b1;
          end else begin
            next_in_unit = 1'b0;
            next_num = is_digit || ch == `RCP_CH_DOT || (num && is_blank);
          end
          if (!is_blank && !in_end && ch != `RCP_CH_SEMI)
            next_last_q = (ch == `RCP_CH_QUERY);
        end
      end
      P_EVAL: begin
        next_pst = P_COLLECT;
        next_cmd.header = hdr;
        next_cmd.unit = unit;
        next_cmd.has_unit = (ulen != 4'h0);
        next_cmd.common = (first == `RCP_CH_STAR);
        next_cmd.query = last_q;
        next_cmd.from_serial = part_ser;
        if (hlen == 4'h0) begin
          next_pst = P_COLLECT; // Empty part is skipped
        end else if (hlen == `RCP_TOK_OVF) begin
          next_cmd_error = 1'b1;
        end else if (hdr == `RCP_H_WAI) begin
          next_wai = 1'b1;
          next_pst = P_WAIT;
        end else if (hdr == `RCP_H_OPC) begin
          next_opc_arm = 1'b1;
        end else if (hdr == `RCP_H_OPCQ) begin
          next_wai = 1'b0;
          next_pst = P_WAIT;
        end else if (hdr == `RCP_H_IDNQ) begin
          next_rsel = 1'b0;
          next_ridx = 5'h0;
          next_resp = '{reply_char(1'b0, 5'h0), 1'b0, part_ser};
          next_pst = P_RESP;
        end else if (hdr == `RCP_H_LOCAL || hdr == `RCP_H_REMOTE
                     || hdr == `RCP_H_LOCKOUT) begin
          next_cmd_error = next_cmd_error || !part_ser;
          ser_loc = part_ser && hdr == `RCP_H_LOCAL;
          ser_rem = part_ser && hdr == `RCP_H_REMOTE;
          ser_llo = part_ser && hdr == `RCP_H_LOCKOUT;
        end else if (ulen != 4'h0 && !unit_ok) begin
          next_cmd_error = 1'b1;
        end else begin
          next_pst = P_DISP;
        end
        // Clear the part buffer for the next one
        next_hdr = 64'h0;
        next_hlen = 4'h0;
        next_unit = 64'h0;
        next_ulen = 4'h0;
        next_in_prm = 1'b0;
        next_in_unit = 1'b0;
        next_num = 1'b0;
        next_last_q = 1'b0;
      end
      P_DISP: begin
        if (cmd_ready) next_pst = P_COLLECT;
      end
      P_WAIT: begin
        if (pend == 4'h0) begin
          next_pst = P_COLLECT;
          if (!wai) begin
            next_rsel = 1'b1;
            next_ridx = 5'h0;
            next_resp = '{reply_char(1'b1, 5'h0), 1'b0, part_ser};
            next_pst = P_RESP;
          end
        end
      end
      P_RESP: begin
        if (resp_ready) begin
          if (resp.last) begin
            next_pst = P_COLLECT;
          end else begin
            next_ridx = ridx + 5'h1;
            next_resp.data = reply_char(rsel, next_ridx);
            next_resp.last = (next_resp.data[6:0] == `RCP_CH_CR);
          end
        end
      end
      default: next_pst = P_COLLECT;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pst <= P_COLLECT;
      hdr <= 64'h0;
      hlen <= 4'h0;
      first <= 7'h00;
      unit <= 64'h0;
      ulen <= 4'h0;
      in_prm <= 1'b0;
      in_unit <= 1'b0;
      num <= 1'b0;
      last_q <= 1'b0;
      part_ser <= 1'b0;
      wai <= 1'b0;
      pend <= 4'h0;
      opc_arm <= 1'b0;
      ridx <= 5'h0;
      rsel <= 1'b0;
      cmd <= '0;
      resp <= '0;
      opc_event <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      pst <= next_pst;
      hdr <= next_hdr;
      hlen <= next_hlen;
      first <= next_first;
      unit <= next_unit;
      ulen <= next_ulen;
      in_prm <= next_in_prm;
      in_unit <= next_in_unit;
      num <= next_num;
      last_q <= next_last_q;
      part_ser <= next_part_ser;
      wai <= next_wai;
      pend <= next_pend;
      opc_arm <= next_opc_arm;
      ridx <= next_ridx;
      rsel <= next_rsel;
      cmd <= next_cmd;
      resp <= next_resp;
      opc_event <= next_opc_event;
      cmd_error <= next_cmd_error;
    end
  end

  assign cmd_valid = (pst == P_DISP);
  assign resp_valid = (pst == P_RESP);

  // ----------------------------------------
  // Local / remote / lockout state
  // ----------------------------------------
  rcp_pkg::rcp_rl_t rl, next_rl;

  // REN fall wins; remote on bus only via REN plus address
  always_comb begin
    next_rl = rl;
    case (rl)
      rcp_pkg::RL_LOCS: begin
        if ((mla_p && ren_s) || ser_rem) next_rl = rcp_pkg::RL_REMS;
        else if (llo_p || ser_llo) next_rl = rcp_pkg::RL_LWLS;
      end
      rcp_pkg::RL_LWLS: begin
        if ((mla_p && ren_s) || ser_rem) next_rl = rcp_pkg::RL_RWLS;
        else if (ser_loc) next_rl = rcp_pkg::RL_LOCS;
      end
      rcp_pkg::RL_REMS: begin
        if (gtl_p || ser_loc || panel_local) next_rl = rcp_pkg::RL_LOCS;
        else if (llo_p || ser_llo) next_rl = rcp_pkg::RL_RWLS;
      end
      rcp_pkg::RL_RWLS: begin
        if (gtl_p) next_rl = rcp_pkg::RL_LWLS;
        else if (ser_loc) next_rl = rcp_pkg::RL_LOCS;
      end
      default: next_rl = rcp_pkg::RL_LOCS;
    endcase
    if (ren_d && !ren_s) next_rl = rcp_pkg::RL_LOCS;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rl <= rcp_pkg::RL_LOCS;
    else rl <= next_rl;
  end

  assign remote = (rl == rcp_pkg::RL_REMS) || (rl == rcp_pkg::RL_RWLS);
  assign lockout = (rl == rcp_pkg::RL_LWLS) || (rl == rcp_pkg::RL_RWLS);

endmodule : rcp_parser
`default_nettype wire

// [sim/rcp_parser_asserts.sv]
// Port checker for the remote command parser
`timescale 1ns/1ps
`default_nettype none
module rcp_parser_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_ren,
  input wire logic ovl_start,
  input wire logic ovl_done,
  input wire logic cmd_ready,
  input wire logic resp_ready,
  input wire rcp_pkg::rcp_cmd_t cmd,
  input wire logic cmd_valid,
  input wire rcp_pkg::rcp_resp_t resp,
  input wire logic resp_valid,
  input wire logic opc_event,
  input wire logic cmd_error,
  input wire logic dev_clear,
  input wire logic dev_trigger,
  input wire logic listen,
  input wire logic remote,
  input wire logic lockout
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] pend; // Mirror of pending overlapped work
  logic [3:0] next_pend; // Saturates both ends
  // Up on start, down on done
  always_comb begin
    next_pend = pend;
    if (ovl_start && !ovl_done && pend != 4'hF) next_pend = pend + 4'h1;
    if (ovl_done && !ovl_start && pend != 4'h0) next_pend = pend - 4'h1;
  end
  // Register the mirror
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pend <= 4'h0;
    else pend <= next_pend;
  end
  property p_cmd_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved");
  property p_resp_hold;
    resp_valid && !resp_ready |=> resp_valid && $stable(resp);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("reply moved");
  property p_opc_pend;
    opc_event |-> $past(pend) == 4'h0;
  endproperty
  a_opc_pend: assert property (p_opc_pend) else $error("early completion");
  property p_err_pulse;
    cmd_error |=> !cmd_error;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error too long");
  property p_clr_pulse;
    dev_clear |=> !dev_clear;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear too long");
  property p_trig_listen;
    dev_trigger |-> listen;
  endproperty
  a_trig_listen: assert property (p_trig_listen) else $error("trigger unaddressed");
  property p_ren_local;
    $fell(bus_ren) |-> ##[1:4] (!remote && !lockout);
  endproperty
  a_ren_local: assert property (p_ren_local) else $error("still remote");
  property p_last_cr;
    resp_valid && resp.last |-> resp.data == 8'h0D;
  endproperty
  a_last_cr: assert property (p_last_cr) else $error("bad reply end");
endmodule : rcp_parser_asserts
`default_nettype wire

// [sim/rcp_host_model.sv]
// Host controller serial transmitter model
`timescale 1ns/1ps
`default_nettype none
module rcp_host_model #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  output logic ser_rx
);
  initial ser_rx = 1'b1; // Idle mark between frames
  // One 8N1 frame LSB first; gap makes a slow host
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      ser_rx = f[i];
      repeat (BIT_CYCLES - 1) @(negedge clk);
    end
    repeat (gap) @(negedge clk);
  endtask : send
  // Whole line closed by CR
  task automatic line(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) send(s[i], gap);
    send(8'h0D, gap);
  endtask : line
endmodule : rcp_host_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench for the remote command parser
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, nrst = 1'b0, bus_dav = 1'b0, bus_atn = 1'b0, bus_eoi = 1'b0;
  logic bus_ren = 1'b0, panel_local = 1'b0, cmd_ready = 1'b0, ovl_start = 1'b0;
  logic ovl_done = 1'b0, resp_ready = 1'b0, ser_rx, bus_hold, listen, cmd_valid;
  logic opc_event, cmd_error, resp_valid, dev_clear, dev_trigger, remote, lockout;
  logic [7:0] bus_dio = 8'h00;
  logic [4:0] bus_addr = 5'h05; // Own address, listen code 8'h25
  rcp_pkg::rcp_cmd_t cmd;
  rcp_pkg::rcp_resp_t resp;
  int bad_count = 0, n_checks = 0, n_err = 0, n_opc = 0, n_ev = 0;
  always #5 clk = ~clk;
  rcp_parser #(.BIT_CYCLES(16)) dut (.clk, .nrst, .ser_rx, .bus_dio, .bus_dav, .bus_atn,
    .bus_eoi, .bus_ren, .bus_addr, .panel_local, .bus_hold, .listen, .cmd, .cmd_valid,
    .cmd_ready, .ovl_start, .ovl_done, .opc_event, .cmd_error, .resp, .resp_valid,
    .resp_ready, .dev_clear, .dev_trigger, .remote, .lockout);
  rcp_host_model #(.BIT_CYCLES(16)) host (.clk, .ser_rx);
  // Pulse tallies
  always @(posedge clk) begin
    n_err <= n_err + (cmd_error === 1'b1);
    n_opc <= n_opc + (opc_event === 1'b1);
    n_ev <= n_ev + (dev_clear === 1'b1) + (dev_trigger === 1'b1);
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One bus byte; next DAV only once the slot is free
  task automatic bb(input logic atn, input logic eoi, input logic [7:0] b);
    @(negedge clk);
    {bus_atn, bus_eoi, bus_dio, bus_dav} = {atn, eoi, b, 1'b1};
    repeat (5) @(negedge clk);
    bus_dav = 1'b0;
    repeat (2000) if (bus_hold) @(negedge clk);
  endtask : bb
  // Bus data line, ended by CR or by LF under EOI
  task automatic bl(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++) bb(1'b0, 1'b0, s[i]);
    bb(1'b0, eoi, eoi ? 8'h0A : 8'h0D);
  endtask : bl
  // Accept one command, late by a cycle; fl is {has_unit, common, query}
  task automatic ac(input logic [63:0] hd, input logic [63:0] un, input logic [2:0] fl);
    repeat (3000) if (cmd_valid !== 1'b1) @(negedge clk);
    @(negedge clk);
    chk(cmd.header, hd);
    chk(cmd.unit, un);
    chk({cmd.has_unit, cmd.common, cmd.query}, fl);
    chk(cmd.from_serial, 1'b0);
    cmd_ready = 1'b1;
    @(negedge clk);
    cmd_ready = 1'b0;
  endtask : ac
  // Take a reply byte by byte, late by a cycle
  task automatic rd(input string s, input logic ser);
    for (int i = 0; i <= s.len(); i++) begin
      repeat (3000) if (resp_valid !== 1'b1) @(negedge clk);
      @(negedge clk);
      chk(resp.data, i < s.len() ? s[i] : 8'h0D);
      chk(resp.last, i == s.len());
      chk(resp.to_serial, ser);
      resp_ready = 1'b1;
      @(negedge clk);
      resp_ready = 1'b0;
    end
  endtask : rd
  task automatic t_idn;
    host.line("*idn?", 0);
    rd("CAL,PC,0,1.0", 1'b1);
  endtask : t_idn
  task automatic t_ovl;
    bb(1'b1, 1'b0, 8'h25);
    chk(listen, 1'b1);
    ovl_start = 1'b1;
    @(negedge clk);
    ovl_start = 1'b0;
    fork
      bl("out 1 mv;*ese?;*opc?", 1'b0);
      begin
        ac(64'h4F5554, 64'h4D56, 3'b100);
        ac(64'h2A4553453F, 64'h0, 3'b011);
      end
    join
    repeat (40) @(negedge clk);
    chk(resp_valid, 1'b0);
    ovl_done = 1'b1;
    @(negedge clk);
    ovl_done = 1'b0;
    rd("1", 1'b0);
    bl("*opc", 1'b1);
    repeat (20) @(negedge clk);
    chk(n_opc, 1);
  endtask : t_ovl
  task automatic t_err;
    bl("out 1 zz", 1'b0);
    bl("remote", 1'b0);
    repeat (20) @(negedge clk);
    chk(n_err, 2);
    chk(cmd_valid, 1'b0);
  endtask : t_err
  task automatic t_rl;
    string s[3] = '{"lockout", "remote", "local"};
    logic [1:0] e[3] = '{2'b01, 2'b11, 2'b00};
    bus_ren = 1'b1;
    bb(1'b1, 1'b0, 8'h25);
    chk(remote, 1'b1);
    panel_local = 1'b1;
    @(negedge clk);
    panel_local = 1'b0;
    @(negedge clk);
    chk(remote, 1'b0);
    bb(1'b1, 1'b0, 8'h25);
    bb(1'b1, 1'b0, 8'h11);
    chk({remote, lockout}, 2'b11);
    bb(1'b1, 1'b0, 8'h14);
    bb(1'b1, 1'b0, 8'h08);
    chk(n_ev, 2);
    bus_ren = 1'b0;
    repeat (6) @(negedge clk);
    chk({remote, lockout}, 2'b00);
    foreach (s[i]) begin
      host.line(s[i], 40);
      chk({remote, lockout}, e[i]);
    end
  endtask : t_rl
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    t_idn();
    t_ovl();
    t_err();
    t_rl();
    conclude();
  end
  // Watchdog well past the expected run
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : tb
bind rcp_parser rcp_parser_asserts u_chk (.clk, .nrst, .bus_ren, .ovl_start, .ovl_done,
  .cmd_ready, .resp_ready, .cmd, .cmd_valid, .resp, .resp_valid, .opc_event, .cmd_error,
  .dev_clear, .dev_trigger, .listen, .remote, .lockout);
`default_nettype wire
